/* src/ussp_pkg.sv */
// Package: register map, bit fields and states of the synchronous serial port
package ussp_pkg;
    localparam int ADDR_W = 6;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_INTCTL = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_PFLAG  = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_PEN    = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_PPRI   = 6'h0C;
    localparam logic [ADDR_W-1:0] OFF_RCSTAT = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_TXBUF  = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_TXSTAT = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_BAUD   = 6'h1C;
    localparam logic [ADDR_W-1:0] OFF_BRGH   = 6'h20;
    localparam logic [ADDR_W-1:0] OFF_BRGL   = 6'h24;
    localparam logic [ADDR_W-1:0] OFF_RXBUF  = 6'h28;

    // cpu_interrupt_control
    localparam int B_GLOBAL_IE  = 7;
    localparam int B_PERIPH_IE  = 6;
    // peripheral_flag_reg / peripheral_enable_reg / peripheral_priority_reg
    localparam int B_RX_FLAG    = 5;
    localparam int B_TX_FLAG    = 4;
    // transmit_status_control
    localparam int B_CLK_MASTER = 7;
    localparam int B_NINTH_TX   = 6;
    localparam int B_TX_EN      = 5;
    localparam int B_CLOCKED    = 4;
    localparam int B_SHIFT_EMPT = 1;
    localparam int B_TX_NINTH   = 0;
    // receive_status_control
    localparam int B_PORT_EN    = 7;
    localparam int B_NINTH_RX   = 6;
    localparam int B_SINGLE_RX  = 5;
    localparam int B_CONT_RX    = 4;
    localparam int B_FRAME_ERR  = 2;
    localparam int B_OVERRUN    = 1;
    localparam int B_RX_NINTH   = 0;
    // baud_control
    localparam int B_IDLE_POL   = 4;
    localparam int B_WIDE_DIV   = 3;

    // Writable bits of each register; the rest read as zero or as status
    localparam logic [7:0] WM_INTCTL = 8'hC0;
    localparam logic [7:0] WM_PEN    = 8'h30;
    localparam logic [7:0] WM_RCSTAT = 8'hF0;
    localparam logic [7:0] WM_TXSTAT = 8'hF1;
    localparam logic [7:0] WM_BAUD   = 8'h18;

    localparam logic [7:0] RST_REG    = 8'h00;
    localparam logic       RST_TXFLAG = 1'b1;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;

    typedef enum logic [1:0] {USSP_IDLE, USSP_TX, USSP_RX} ussp_state_t;
endpackage

/* src/ussp_top.sv */
// Synchronous serial port: master/slave shifter with AXI4-Lite registers
//
// Functional notes
// [RULE1] Load shifter from buffer only after last bit out, at once if buffer full.
// [RULE2] Buffer-to-shifter move takes one cycle, then buffer empty and flag set.
// [RULE3] Transmit-empty flag ignores software writes; only a buffer write clears it.
// [RULE4] Transmit-empty flag sets regardless of its interrupt enable.
// [RULE5] Shifter-empty is read-only status, no interrupt, shifter not addressable.
// [RULE6] Software programs divisor and width before enabling master transfers.
// [RULE7] Master mode needs clocked mode, port enable and clock-source master set.
// [RULE8] Ninth bit enabled: each word carries tx ninth bit, loaded beforehand.
// [RULE9] With transmit enabled, a buffer write starts a transmission.
// [RULE10] Reception enabled by single or continuous receive enable; code honours single receive in master mode only.
// [RULE11] Receive data sampled on falling edge of the shift clock; code samples on the trail edge, which is rising when idle polarity is set.
// [RULE12] Single receives one word; continuous repeats; continuous wins if both.
// [RULE13] Software clears both receive enables while configuring reception.
// [RULE14] Completed word sets receive flag; interrupt only if its enable set.
// [RULE15] Receive status shows ninth bit and error flags; read it first.
// [RULE16] Lower eight received bits are read through the receive buffer.
// [RULE17] Clearing continuous receive clears pending reception errors.
// [RULE18] Interrupt reaches processor only with global and peripheral enables set.
// [RULE19] Clock-source master clear selects slave mode with external shift clock.
// [RULE20] Slave mode keeps shifting in low-power states.
// [RULE21] Unimplemented register bits read as zero.
// [RULE22] Master drives shift clock on the clock pin for every bit.
// [RULE23] Clock pin idles high with idle polarity set, low when clear.
// [RULE24] Half-duplex: no reception while transmitting, and the reverse.
// [RULE25] Port enable turns pins into shift clock and data line.
// [RULE26] Master shift clock runs only during a word, else idle level.
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module ussp_top
(
    input  wire logic                         mclk,
    input  wire logic                         rst_n,
    input  wire logic [ussp_pkg::ADDR_W-1:0]  awaddr,
    input  wire logic                         awvalid,
    output logic                              awready,
    input  wire logic [31:0]                  wdata,
    input  wire logic [3:0]                   wstrb,
    input  wire logic                         wvalid,
    output logic                              wready,
    output logic [1:0]                        bresp,
    output logic                              bvalid,
    input  wire logic                         bready,
    input  wire logic [ussp_pkg::ADDR_W-1:0]  araddr,
    input  wire logic                         arvalid,
    output logic                              arready,
    output logic [31:0]                       rdata,
    output logic [1:0]                        rresp,
    output logic                              rvalid,
    input  wire logic                         rready,
    input  wire logic                         sclk_i,
    output logic                              sclk_o,
    output logic                              sclk_oe_n,
    input  wire logic                         sdat_i,
    output logic                              sdat_o,
    output logic                              sdat_oe_n,
    input  wire logic                         low_power,
    output logic                              irq
);
    import ussp_pkg::*;

    logic [7:0]  intctl_q, pen_q, ppri_q, rcstat_q, txstat_q, baud_q, brgh_q, brgl_q;
    logic [7:0]  txbuf_q, rxbuf_q, rd_mux;
    logic        buf_full_q, txflag_q, rxflag_q, overrun_q, rx_ninth_q;
    logic        bvalid_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [ADDR_W-1:0] wa, ra;
    logic        wr_fire, rd_fire, wr_hit, rd_hit;
    logic        wr_txbuf, wr_rcstat, rd_rxbuf;
    ussp_state_t state_q;
    logic [3:0]  bit_cnt_q, last_bit;
    logic [8:0]  tx_shift_q, rsr_q, rx_word;
    logic [15:0] div_cnt_q, divisor;
    logic        phase_q, tick;
    logic        sclk_m1_q, sclk_m2_q, sclk_prev_q, sdat_m1_q, sdat_m2_q;
    logic        port_on, mode_on, master, pol, lead, trail, last;
    logic        rx_want, tx_start, rx_start, tx_reload, load, rx_done, rx_overrun;

    assign port_on = rcstat_q[B_PORT_EN];
    assign mode_on = port_on && txstat_q[B_CLOCKED]; // RULE7
    assign master  = txstat_q[B_CLK_MASTER];
    assign pol     = baud_q[B_IDLE_POL];

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: write takes address and data together
    assign wa      = {awaddr[ADDR_W-1:2], 2'b00};
    assign ra      = {araddr[ADDR_W-1:2], 2'b00};
    assign awready = wvalid && !bvalid_q;
    assign wready  = awvalid && !bvalid_q;
    assign wr_fire = awvalid && wvalid && !bvalid_q;
    assign arready = !rvalid_q;
    assign rd_fire = arvalid && !rvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = rdata_q;

    assign wr_hit = wa inside {OFF_INTCTL, OFF_PFLAG, OFF_PEN, OFF_PPRI, OFF_RCSTAT, OFF_TXBUF,
                               OFF_TXSTAT, OFF_BAUD, OFF_BRGH, OFF_BRGL, OFF_RXBUF};
    assign rd_hit = ra inside {OFF_INTCTL, OFF_PFLAG, OFF_PEN, OFF_PPRI, OFF_RCSTAT, OFF_TXBUF,
                               OFF_TXSTAT, OFF_BAUD, OFF_BRGH, OFF_BRGL, OFF_RXBUF};
    assign wr_txbuf  = wr_fire && wstrb[0] && (wa == OFF_TXBUF);
    assign wr_rcstat = wr_fire && wstrb[0] && (wa == OFF_RCSTAT);
    assign rd_rxbuf  = rd_fire && (ra == OFF_RXBUF);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLV;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Unused bit positions are zero in every read value
    always_comb begin
        rd_mux = 8'h00;
        unique case (ra)
            OFF_INTCTL: rd_mux = intctl_q;
            OFF_PFLAG:  rd_mux = {2'b00, rxflag_q, txflag_q, 4'h0};
            OFF_PEN:    rd_mux = pen_q;
            OFF_PPRI:   rd_mux = ppri_q;
            OFF_RCSTAT: rd_mux = rcstat_q | {5'h00, 1'b0, overrun_q, rx_ninth_q}; // RULE15 RULE21
            OFF_TXBUF:  rd_mux = txbuf_q;
            OFF_TXSTAT: rd_mux = txstat_q | {6'h00, state_q != USSP_TX, 1'b0}; // RULE5
            OFF_BAUD:   rd_mux = baud_q;
            OFF_BRGH:   rd_mux = brgh_q;
            OFF_BRGL:   rd_mux = brgl_q;
            OFF_RXBUF:  rd_mux = rxbuf_q; // RULE16
            default:    rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLV;
            rdata_q  <= {24'h00_0000, rd_mux};
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers; single receive enable self-clears after its word
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            intctl_q <= RST_REG;
            pen_q    <= RST_REG;
            ppri_q   <= RST_REG;
            rcstat_q <= RST_REG;
            txstat_q <= RST_REG;
            baud_q   <= RST_REG;
            brgh_q   <= RST_REG;
            brgl_q   <= RST_REG;
        end else begin
            if (rx_done && !rcstat_q[B_CONT_RX]) begin
                rcstat_q[B_SINGLE_RX] <= 1'b0; // RULE12
            end
            if (wr_fire && wstrb[0]) begin
                unique case (wa)
                    OFF_INTCTL: intctl_q <= wdata[7:0] & WM_INTCTL;
                    OFF_PEN:    pen_q    <= wdata[7:0] & WM_PEN;
                    OFF_PPRI:   ppri_q   <= wdata[7:0] & WM_PEN;
                    OFF_RCSTAT: rcstat_q <= wdata[7:0] & WM_RCSTAT;
                    OFF_TXSTAT: txstat_q <= wdata[7:0] & WM_TXSTAT;
                    OFF_BAUD:   baud_q   <= wdata[7:0] & WM_BAUD;
                    OFF_BRGH:   brgh_q   <= wdata[7:0];
                    OFF_BRGL:   brgl_q   <= wdata[7:0];
                    default:    ;
                endcase
            end
        end
    end

    // Transmit buffer; a load is never taken in the cycle of a buffer write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            txbuf_q    <= RST_REG;
            buf_full_q <= 1'b0;
            txflag_q   <= RST_TXFLAG;
        end else if (wr_txbuf) begin
            txbuf_q    <= wdata[7:0];
            buf_full_q <= 1'b1;
            txflag_q   <= 1'b0; // RULE3
        end else if (load) begin
            buf_full_q <= 1'b0;
            txflag_q   <= 1'b1; // RULE2 RULE4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_m1_q   <= 1'b0;
            sclk_m2_q   <= 1'b0;
            sclk_prev_q <= 1'b0;
            sdat_m1_q   <= 1'b0;
            sdat_m2_q   <= 1'b0;
        end else begin
            sclk_m1_q   <= sclk_i;
            sclk_m2_q   <= sclk_m1_q;
            sclk_prev_q <= sclk_m2_q;
            sdat_m1_q   <= sdat_i;
            sdat_m2_q   <= sdat_m1_q;
        end
    end

    // Master clock: one tick per divisor+1 cycles, each tick a half period
    assign divisor = baud_q[B_WIDE_DIV] ? {brgh_q, brgl_q} : {8'h00, brgl_q};
    assign tick    = (div_cnt_q == divisor) && !low_power;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= 16'h0000;
            phase_q   <= 1'b0;
        end else if (!master || state_q == USSP_IDLE || !mode_on || (state_q == USSP_RX && !rx_want)) begin
            div_cnt_q <= 16'h0000; // RULE26
            phase_q   <= 1'b0;
        end else if (tick) begin
            div_cnt_q <= 16'h0000;
            phase_q   <= !phase_q; // RULE22
        end else if (!low_power) begin
            div_cnt_q <= div_cnt_q + 16'h0001;
        end
    end

    // Leaving idle level is the lead edge, returning is the trail edge
    always_comb begin
        if (master) begin
            lead  = tick && !phase_q; // RULE7
            trail = tick && phase_q;
        end else begin
            lead  = (sclk_m2_q ^ pol) && !(sclk_prev_q ^ pol); // RULE19 RULE20
            trail = !(sclk_m2_q ^ pol) && (sclk_prev_q ^ pol);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift engine
    assign last_bit   = txstat_q[B_NINTH_TX] && state_q == USSP_TX ? 4'd8 :
                        rcstat_q[B_NINTH_RX] && state_q == USSP_RX ? 4'd8 : 4'd7;
    assign last       = trail && (bit_cnt_q == last_bit);
    assign rx_want    = mode_on && !overrun_q && (rcstat_q[B_CONT_RX] ||
                        (rcstat_q[B_SINGLE_RX] && master)); // RULE10 RULE12
    assign tx_start   = mode_on && state_q == USSP_IDLE && buf_full_q &&
                        txstat_q[B_TX_EN] && !wr_txbuf; // RULE9
    assign rx_start   = state_q == USSP_IDLE && !tx_start && rx_want; // RULE24
    assign tx_reload  = state_q == USSP_TX && last && buf_full_q && txstat_q[B_TX_EN] &&
                        mode_on && !wr_txbuf; // RULE1
    assign load       = tx_start || tx_reload;
    assign rx_done    = state_q == USSP_RX && last;
    assign rx_overrun = rx_done && rxflag_q && !rd_rxbuf;

    always_comb begin
        rx_word = rsr_q;
        rx_word[bit_cnt_q] = sdat_m2_q;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= USSP_IDLE;
        end else begin
            unique case (state_q)
                USSP_IDLE: if (tx_start) begin
                    state_q <= USSP_TX;
                end else if (rx_start) begin
                    state_q <= USSP_RX;
                end
                USSP_TX: if (!mode_on || (last && !tx_reload)) begin
                    state_q <= USSP_IDLE;
                end
                USSP_RX: if (!rx_want || rx_done) begin
                    state_q <= USSP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_q  <= 4'd0;
            tx_shift_q <= 9'h000;
            rsr_q      <= 9'h000;
        end else if (load) begin
            bit_cnt_q  <= 4'd0;
            tx_shift_q <= {txstat_q[B_TX_NINTH], txbuf_q}; // RULE8
        end else if (rx_start) begin
            bit_cnt_q  <= 4'd0;
            rsr_q      <= 9'h000;
        end else if (trail && state_q != USSP_IDLE) begin
            bit_cnt_q  <= bit_cnt_q + 4'd1;
            tx_shift_q <= {1'b0, tx_shift_q[8:1]};
            rsr_q      <= rx_word; // RULE11
        end
    end

    // Receive holding; a full holding register keeps its word on overrun
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rxbuf_q   <= RST_REG;
            rx_ninth_q <= 1'b0;
            rxflag_q  <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            if (rx_done && !rx_overrun) begin
                rxbuf_q  <= rx_word[7:0]; // RULE16
                rx_ninth_q <= rcstat_q[B_NINTH_RX] && rx_word[8]; // RULE15
                rxflag_q <= 1'b1; // RULE14
            end else if (rd_rxbuf) begin
                rxflag_q <= 1'b0;
            end
            if (rx_overrun) begin
                overrun_q <= 1'b1;
            end else if (wr_rcstat && !wdata[B_CONT_RX]) begin
                overrun_q <= 1'b0; // RULE17
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins and interrupt request
    assign sclk_o    = master ? (phase_q ^ pol) : pol; // RULE23
    assign sclk_oe_n = !(mode_on && master); // RULE25
    assign sdat_o    = tx_shift_q[0];
    assign sdat_oe_n = !(port_on && state_q == USSP_TX); // RULE24 RULE25
    assign irq     = intctl_q[B_GLOBAL_IE] && intctl_q[B_PERIPH_IE] &&
                     ((rxflag_q && pen_q[B_RX_FLAG]) || (txflag_q && pen_q[B_TX_FLAG])); // RULE18

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_load_sets_flag: assert property (load && !wr_txbuf |=> txflag_q && !buf_full_q) // RULE2
        else $error("flag not set after load");
    a_load_after_last: assert property (load |-> state_q == USSP_IDLE || last) // RULE1
        else $error("shifter loaded mid word");
    a_flag_holds: assert property (txflag_q && !wr_txbuf |=> txflag_q) // RULE3
        else $error("transmit flag dropped without write");
    a_irq_gated: assert property (irq |-> intctl_q[7:6] == 2'b11) // RULE18
        else $error("interrupt without enables");
    a_rx_flag_set: assert property (rx_done && !rxflag_q |=> rxflag_q && rxbuf_q == $past(rx_word[7:0])) // RULE14
        else $error("received word not delivered");
    a_rx_no_drive: assert property (state_q == USSP_RX |-> sdat_oe_n) // RULE24
        else $error("data driven while receiving");
    a_clk_idle: assert property (master && state_q == USSP_IDLE |-> sclk_o == pol) // RULE26
        else $error("master clock not at idle level");
    a_pins_released: assert property (!port_on |-> sclk_oe_n && sdat_oe_n) // RULE25
        else $error("pins driven with port disabled");
    a_single_once: assert property (rx_done && !rcstat_q[B_CONT_RX] && !wr_fire |=> !rcstat_q[B_SINGLE_RX]) // RULE12
        else $error("single receive did not stop");
    a_error_clear: assert property (wr_rcstat && !wdata[B_CONT_RX] && !rx_overrun |=> !overrun_q) // RULE17
        else $error("error not cleared");
    a_shifter_empty_status: assert property ($rose(state_q == USSP_TX) |-> $past(load)) // RULE5
        else $error("shifter busy without load");

    c_tx_reload: cover property (tx_reload);
    c_rx_word:   cover property (rx_done);
    c_overrun:   cover property (rx_overrun);
    c_slave_rx:  cover property (rx_done && !master);
    c_master_bit: cover property (master && lead && state_q == USSP_TX);
endmodule

/* bench/ussp_peer.sv */
// Serial peer model on the shift clock and data lines
`timescale 1ns/1ps
module ussp_peer (
    input  wire logic       sclk,
    input  wire logic       sdat,
    input  wire logic       sdat_oe_n,
    input  wire logic       arm,
    input  wire logic       go,
    input  wire logic [7:0] tx_byte,
    output logic            pk,
    output logic            pd,
    output logic [8:0]      word,
    output int              cnt
);
    int idx;
    initial begin
        pk = 1'b0;
        pd = 1'b0;
    end
    always @(posedge arm) begin
        idx = 0;
        cnt = 0;
    end
    // Change data on the active edge so it is settled at the sampling edge
    always @(posedge sclk) begin
        word = {sdat, word[8:1]};
        cnt = cnt + 1;
        if (sdat_oe_n) begin
            // Past the word the line keeps moving, never a stale bit
            pd = (idx < 8) ? tx_byte[idx] : ~pd;
            idx = idx + 1;
        end
    end
    // External clock only inside a frame
    always @(posedge go) begin
        repeat (8) begin
            #200 pk = 1'b1;
            #200 pk = 1'b0;
        end
    end
endmodule

/* bench/ussp_top_bench.sv */
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ps
module ussp_top_bench;
    import ussp_pkg::*;
    logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, low_power, arm, go;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic        sclk_o, sclk_oe_n, sdat_o, sdat_oe_n, pk, pd, sclk, sdat;
    logic [7:0]  tx_byte;
    logic [8:0]  word;
    int          cnt, mismatches, comparisons, cycles;
    assign sclk = sclk_oe_n ? pk : sclk_o;
    assign sdat = sdat_oe_n ? pd : sdat_o;
    ussp_top dut (.mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .sclk_i(sclk), .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n),
        .sdat_i(sdat), .sdat_o(sdat_o), .sdat_oe_n(sdat_oe_n), .low_power(low_power), .irq(irq));
    ussp_peer peer (.sclk(sclk), .sdat(sdat), .sdat_oe_n(sdat_oe_n), .arm(arm), .go(go), .tx_byte(tx_byte),
        .pk(pk), .pd(pd), .word(word), .cnt(cnt));
    ////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do @(posedge mclk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        bready  <= 1'b1;
        do @(posedge mclk); while (!bvalid);
        bready  <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(posedge mclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready  <= 1'b0;
    endtask
    task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, exp);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask
    task automatic arm_peer(input logic [7:0] b);
        tx_byte <= b;
        arm     <= 1'b1;
        @(posedge mclk);
        arm     <= 1'b0;
    endtask
    task automatic wait_cnt(input int n);
        do @(posedge mclk); while (cnt < n);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        rchk(OFF_PFLAG, 32'h10);
        wr(OFF_PFLAG, 8'h00);
        rchk(OFF_PFLAG, 32'h10);
        rchk(OFF_TXSTAT, 32'h02);
        wr(OFF_INTCTL, 8'hFF);
        rchk(OFF_INTCTL, 32'hC0);
        rd(6'h2C, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLV});
        wr(OFF_INTCTL, 8'h00);
        $display("t_regs done");
    endtask
    task automatic t_tx();
        wr(OFF_BRGL, 8'h03);
        wr(OFF_TXSTAT, 8'hF1);
        wr(OFF_RCSTAT, 8'h80);
        arm_peer(8'h00);
        wr(OFF_TXBUF, 8'hA5);
        rchk(OFF_PFLAG, 32'h10);
        rchk(OFF_TXSTAT, 32'hF1);
        // Second word queued behind the first: no gap expected
        wr(OFF_TXBUF, 8'h3C);
        rchk(OFF_PFLAG, 32'h00);
        wait_cnt(9);
        chk({23'h0, word}, 32'h1A5);
        wait_cnt(18);
        chk({23'h0, word}, 32'h13C);
        repeat (40) @(posedge mclk);
        chk(cnt, 18);
        chk({31'h0, sclk}, 32'h0);
        rchk(OFF_TXSTAT, 32'hF3);
        wr(OFF_BAUD, 8'h10);
        repeat (4) @(posedge mclk);
        chk({31'h0, sclk}, 32'h1);
        wr(OFF_BAUD, 8'h00);
        $display("t_tx done");
    endtask
    task automatic t_rx();
        logic [31:0] d;
        logic [1:0]  r;
        wr(OFF_TXSTAT, 8'h90);
        wr(OFF_RCSTAT, 8'h80);
        wr(OFF_PEN, 8'h20);
        wr(OFF_INTCTL, 8'hC0);
        arm_peer(8'h6B);
        wr(OFF_RCSTAT, 8'hA0);
        do @(posedge mclk); while (irq !== 1'b1);
        rd(OFF_RCSTAT, d, r);
        chk({29'h0, d[2:0]}, 32'h0);
        rchk(OFF_RXBUF, 32'h6B);
        chk({31'h0, irq}, 32'h0);
        repeat (100) @(posedge mclk);
        chk(cnt, 8);
        $display("t_rx done");
    endtask
    task automatic t_slave();
        wr(OFF_RCSTAT, 8'h80);
        wr(OFF_TXSTAT, 8'h10);
        wr(OFF_RCSTAT, 8'h90);
        low_power <= 1'b1;
        arm_peer(8'hC4);
        go <= 1'b1;
        do @(posedge mclk); while (irq !== 1'b1);
        go <= 1'b0;
        // Second word left unread behind the first: overrun keeps the old word
        arm_peer(8'h3E);
        go <= 1'b1;
        repeat (80) @(posedge mclk);
        low_power <= 1'b0;
        go        <= 1'b0;
        rchk(OFF_RCSTAT, 32'h92);
        rchk(OFF_RXBUF, 32'hC4);
        wr(OFF_RCSTAT, 8'h80);
        rchk(OFF_RCSTAT, 32'h80);
        chk({31'h0, sclk_oe_n}, 32'h1);
        $display("t_slave done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Whole run needs under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, low_power, arm, go} = '0;
        {awaddr, araddr, wdata, tx_byte} = '0;
        wstrb = 4'hF;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_tx();
        t_rx();
        t_slave();
        final_report();
    end
endmodule
